// ==== hw/osl_ctrl.sv ====
// Oscillator select and low-power mode controller with APB registers
`timescale 1ns/1ps
`default_nettype none
module osl_ctrl
	import osl_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU core
	input  wire logic        stop_req,
	input  wire logic        wait_req,
	output logic             wake,
	output logic [15:0]      vector,
	output logic             clr_i_mask,
	output logic             chip_reset_req,
	// Peripheral side
	input  wire osl_irq_t    periph_irq,
	input  wire logic        wdog_timeout,
	output logic             core_timer_clear,
	output logic             prog_timer_clear,
	// Pins
	input  wire logic        irq_pin_n,
	input  wire logic [3:0]  porta_wake_pins,
	input  wire logic        reset_pin_n,
	// Clock controls
	output osl_clk_t         clk
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	osl_state_t  state;
	logic        ext_interrupt_enable;
	logic        ext_interrupt_flag;
	logic        osc_select_low;
	logic        osc_select_high;
	logic        delay_long;
	logic        stop_as_halt_select;
	logic        porta_wake_option;
	logic        irq_pin_prev;
	logic [3:0]  porta_prev;
	logic [1:0]  sw_cnt;
	logic        ext_edge;
	logic        hard_reset;
	logic        wake_wait;
	logic        enter_low;
	logic        enter_stop;
	logic        want_ext;
	logic        acc_go;
	logic        wr_go;
	logic        mapped;
	logic        dly_start;
	logic        dly_done;
	logic [31:0] rdata;
	logic [15:0] next_vector;
	osl_clk_t    next_clk;

	// ------------------------------------------------------------
	// Wake and reset sources
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_prev <= 1'b1;
			porta_prev   <= 4'h0;
		end else begin
			irq_pin_prev <= irq_pin_n;
			porta_prev   <= porta_wake_pins;
		end
	end

	always_comb begin
		ext_edge = (irq_pin_prev && !irq_pin_n)
			|| (porta_wake_option && |(~porta_prev & porta_wake_pins));
		// Held-low reset pin keeps the mode and control bits in reset and clears the flag unless a new enabled request sets it; option bits are kept
		hard_reset = !reset_pin_n
			|| (wdog_timeout && clk.wdog_en);
		wake_wait = ext_edge || (|periph_irq);
		enter_low = (state == ST_RUN) && (stop_req || wait_req) && !hard_reset;
		enter_stop = (state == ST_RUN) && stop_req && !stop_as_halt_select && !hard_reset;
		dly_start = !hard_reset && (((state == ST_STOP) && ext_edge)
			|| ((state == ST_HALT) && wake_wait));
	end

	// Fixed priority when several sources wake in one cycle
	always_comb begin
		if (ext_edge) begin
			next_vector = VEC_EXT;
		end else if (periph_irq.core_tmr) begin
			next_vector = VEC_CORE;
		end else if (periph_irq.prog_tmr) begin
			next_vector = VEC_PROG;
		end else if (periph_irq.serial) begin
			next_vector = VEC_SERIAL;
		end else begin
			next_vector = VEC_ANALOG;
		end
	end

	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_RUN;
		end else if (hard_reset) begin
			state <= ST_RUN;
		end else begin
			case (state)
				ST_RUN: begin
					if (stop_req) begin
						state <= stop_as_halt_select ? ST_HALT : ST_STOP;
					end else if (wait_req) begin
						state <= ST_WAIT;
					end
				end
				ST_STOP: begin
					if (ext_edge) begin
						state <= ST_RECOVER;
					end
				end
				ST_WAIT: begin
					if (wake_wait) begin
						state <= ST_RUN;
					end
				end
				ST_HALT: begin
					if (wake_wait) begin
						state <= ST_RECOVER;
					end
				end
				ST_RECOVER: begin
					if (dly_done) begin
						state <= ST_RUN;
					end
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	osl_delay u_delay (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (dly_start),
		.long_sel (delay_long),
		.done     (dly_done)
	);

	// ------------------------------------------------------------
	// CPU side outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake           <= 1'b0;
			vector         <= VEC_RESET;
			chip_reset_req <= 1'b0;
		end else begin
			chip_reset_req <= hard_reset;
			wake <= !hard_reset && (((state == ST_WAIT) && wake_wait)
				|| ((state == ST_RECOVER) && dly_done));
			if (hard_reset) begin
				vector <= VEC_RESET;
			end else if (((state == ST_WAIT) || (state == ST_HALT)) && wake_wait) begin
				vector <= next_vector;
			end else if ((state == ST_STOP) && ext_edge) begin
				vector <= VEC_EXT;
			end
		end
	end

	// Entry side effects last one cycle; the peripherals do the clearing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_timer_clear <= 1'b0;
			prog_timer_clear <= 1'b0;
			clr_i_mask       <= 1'b0;
		end else begin
			core_timer_clear <= enter_stop;
			prog_timer_clear <= enter_stop;
			clr_i_mask       <= enter_low;
		end
	end

	// ------------------------------------------------------------
	// Control and status bits
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_interrupt_enable <= IRQ_EN_RST;
			osc_select_high      <= SEL_HI_RST;
			osc_select_low       <= SEL_LO_RST;
		end else if (hard_reset) begin
			ext_interrupt_enable <= IRQ_EN_RST;
			osc_select_high      <= SEL_HI_RST;
			osc_select_low       <= SEL_LO_RST;
		end else begin
			if (wr_go && (paddr == ADDR_ICS)) begin
				ext_interrupt_enable <= pwdata[ICS_IRQ_EN];
				osc_select_high      <= pwdata[ICS_SEL_HI];
				osc_select_low       <= pwdata[ICS_SEL_LO];
			end
			if (enter_low) begin
				ext_interrupt_enable <= 1'b1;
			end
		end
	end

	// A new request in the ack cycle wins over the ack
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_interrupt_flag <= 1'b0;
		end else if (ext_edge && ext_interrupt_enable) begin
			ext_interrupt_flag <= 1'b1;
		end else if (hard_reset || (wr_go && (paddr == ADDR_ICS) && pwdata[ICS_ACK])) begin
			ext_interrupt_flag <= 1'b0;
		end
	end

	// Option bits model a non-volatile word, so only power-on reset clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{porta_wake_option, stop_as_halt_select, delay_long} <= OPT_RST;
		end else if (wr_go && (paddr == ADDR_OPT)) begin
			delay_long          <= pwdata[OPT_LONG];
			stop_as_halt_select <= pwdata[OPT_HALT];
			porta_wake_option   <= pwdata[OPT_PAWAKE];
		end
	end

	// ------------------------------------------------------------
	// Clock control
	// ------------------------------------------------------------
	assign want_ext = osc_select_low && !osc_select_high;

	// The CPU clock is gated off before and after the select flips,
	// so neither source is cut mid-pulse; software must have let the
	// external oscillator settle first, this logic does not measure it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_cnt <= 2'h0;
		end else if (sw_cnt != 2'h0) begin
			sw_cnt <= sw_cnt - 2'h1;
		end else if (want_ext != clk.sel_ext) begin
			sw_cnt <= SWITCH_GAP;
		end
	end

	always_comb begin
		next_clk.int_osc_en = !want_ext && (state != ST_STOP);
		next_clk.ext_osc_en = osc_select_low && (state != ST_STOP);
		next_clk.sel_ext = (sw_cnt == 2'h1) ? want_ext : clk.sel_ext;
		next_clk.cpu_en = (state == ST_RUN) && (sw_cnt == 2'h0)
			&& (want_ext == clk.sel_ext);
		next_clk.periph_en = (state != ST_STOP);
		next_clk.wdog_en = (state != ST_STOP);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk <= '{int_osc_en: 1'b1, ext_osc_en: 1'b0, sel_ext: 1'b0,
				cpu_en: 1'b1, periph_en: 1'b1, wdog_en: 1'b1};
		end else begin
			clk <= next_clk;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign acc_go = psel && penable && !pready;
	assign wr_go  = psel && penable && pready && pwrite;
	assign mapped = (paddr == ADDR_ICS) || (paddr == ADDR_OPT) || (paddr == ADDR_STAT);

	always_comb begin
		rdata = 32'h0000_0000;
		case (paddr)
			ADDR_ICS: begin
				rdata[ICS_IRQ_EN] = ext_interrupt_enable;
				rdata[ICS_SEL_HI] = osc_select_high;
				rdata[ICS_FLAG]   = ext_interrupt_flag;
				rdata[ICS_SEL_LO] = osc_select_low;
			end
			ADDR_OPT: begin
				rdata[OPT_LONG]   = delay_long;
				rdata[OPT_HALT]   = stop_as_halt_select;
				rdata[OPT_PAWAKE] = porta_wake_option;
			end
			ADDR_STAT: begin
				rdata = {vector, 13'h0000, state};
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= acc_go;
			if (acc_go) begin
				pslverr <= !mapped;
				prdata  <= pwrite ? 32'h0000_0000 : rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [12:0] rec_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_cnt <= 13'h0000;
		end else begin
			rec_cnt <= (state == ST_RECOVER) ? rec_cnt + 13'h0001 : 13'h0000;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_osc_map;
		(state == ST_RUN) && !hard_reset |=> clk.int_osc_en == !$past(want_ext);
	endproperty
	a_osc_map: assert property (p_osc_map) else $error("internal osc enable wrong");

	property p_reset_sel;
		!reset_pin_n |=> osc_select_high && !osc_select_low ##1 clk.int_osc_en;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("reset did not select internal");

	property p_both_set;
		osc_select_low && osc_select_high && (state == ST_RUN)
			|=> clk.int_osc_en && clk.ext_osc_en && (!clk.sel_ext || (sw_cnt != 2'h0));
	endproperty
	a_both_set: assert property (p_both_set) else $error("both-set select wrong");

	property p_stop_off;
		(state == ST_STOP) |=> !clk.int_osc_en && !clk.ext_osc_en && !clk.periph_en;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("clocks run in stop");

	property p_stop_entry;
		enter_stop |=> core_timer_clear && prog_timer_clear && clr_i_mask
			&& ext_interrupt_enable ##1 !core_timer_clear;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop entry effects wrong");

	property p_ext_wake;
		(state == ST_WAIT) && ext_edge && !hard_reset
			|=> wake && (vector == VEC_EXT) && (state == ST_RUN);
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("wait wake wrong");

	property p_recover_len;
		(state == ST_RECOVER) && dly_done
			|-> rec_cnt == {1'b0, (delay_long ? STAB_LONG : STAB_SHORT)};
	endproperty
	a_recover_len: assert property (p_recover_len) else $error("recovery length wrong");

	property p_wait_gate;
		(state == ST_WAIT) && ($past(state) == ST_WAIT)
			|-> !clk.cpu_en && clk.periph_en && clk.wdog_en;
	endproperty
	a_wait_gate: assert property (p_wait_gate) else $error("wait gating wrong");

	property p_halt_wdog;
		(state == ST_HALT) && ($past(state) == ST_HALT) |-> clk.wdog_en && clk.periph_en;
	endproperty
	a_halt_wdog: assert property (p_halt_wdog) else $error("halt stopped watchdog");

	property p_flag_set;
		ext_edge && ext_interrupt_enable |=> ext_interrupt_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

endmodule : osl_ctrl
`default_nettype wire

// ==== hw/osl_delay.sv ====
// Recovery delay counter used after stop and halt
`timescale 1ns/1ps
`default_nettype none
module osl_delay
	import osl_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic start,
	input  wire logic long_sel,
	// Result
	output logic      done
);

	logic [11:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 12'h000;
		end else if (start) begin
			cnt <= long_sel ? STAB_LONG : STAB_SHORT;
		end else if (cnt != 12'h000) begin
			cnt <= cnt - 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
		end else begin
			done <= (cnt == 12'h001) && !start;
		end
	end

endmodule : osl_delay
`default_nettype wire

// ==== hw/osl_pkg.sv ====
// Constants and types for the oscillator select and low-power mode controller
//
// What this block does
// - Select bits 00/10 run internal osc only; 01 runs external osc only.
// - Reset clears low select bit and sets high one.
// - Both bits set: external osc runs to settle, internal osc clocks chip.
// - Stop halts both oscillators and all clocks, select bits untouched.
// - Stop entry clears core timer flags and their enables.
// - Stop entry clears programmable timer flags and their three enables.
// - Stop or wait entry sets external irq enable, clears CPU mask.
// - Irq pin falling edge wakes to ext vector; reset pin low resets.
// - With port A option, rising edge on pins 0-3 wakes to ext vector.
// - Leaving stop waits 16 or 4064 bus cycles per delay option.
// - Wait gates only the CPU clock; oscillator and peripherals run.
// - Core timer interrupt wakes from wait to its vector.
// - Programmable timer interrupt wakes from wait to its vector.
// - Serial port transfer-done interrupt wakes from wait to its vector.
// - Analog comparison interrupt wakes from wait to its vector.
// - Watchdog runs in wait; timeout resets chip to reset vector.
// - Leaving wait resumes at once, no delay.
// - Halt option turns stop into halt: wait-like, with recovery delay.
// - Stop as halt never stops the watchdog.
// - Pending external request sets read-only flag; ack bit clears it.
package osl_pkg;

	localparam logic [7:0]  ADDR_ICS  = 8'h00;
	localparam logic [7:0]  ADDR_OPT  = 8'h04;
	localparam logic [7:0]  ADDR_STAT = 8'h08;

	localparam int ICS_IRQ_EN = 7;
	localparam int ICS_SEL_HI = 4;
	localparam int ICS_FLAG   = 3;
	localparam int ICS_ACK    = 1;
	localparam int ICS_SEL_LO = 0;
	localparam int OPT_LONG   = 0;
	localparam int OPT_HALT   = 1;
	localparam int OPT_PAWAKE = 2;

	localparam logic       IRQ_EN_RST = 1'b1;
	localparam logic       SEL_HI_RST = 1'b1;
	localparam logic       SEL_LO_RST = 1'b0;
	localparam logic [2:0] OPT_RST    = 3'h0;

	// Stabilisation counts, in bus cycles
	localparam logic [11:0] STAB_SHORT = 12'h010;
	localparam logic [11:0] STAB_LONG  = 12'hfe0;
	localparam logic [1:0]  SWITCH_GAP = 2'h2;

	localparam logic [15:0] VEC_RESET  = 16'h1ffe;
	localparam logic [15:0] VEC_EXT    = 16'h1ffa;
	localparam logic [15:0] VEC_CORE   = 16'h1ff8;
	localparam logic [15:0] VEC_PROG   = 16'h1ff6;
	localparam logic [15:0] VEC_SERIAL = 16'h1ff4;
	localparam logic [15:0] VEC_ANALOG = 16'h1ff2;

	typedef enum logic [2:0] {ST_RUN, ST_STOP, ST_WAIT, ST_HALT, ST_RECOVER} osl_state_t;

	typedef struct packed {
		logic core_tmr;
		logic prog_tmr;
		logic serial;
		logic analog;
	} osl_irq_t;

	typedef struct packed {
		logic int_osc_en;
		logic ext_osc_en;
		logic sel_ext;
		logic cpu_en;
		logic periph_en;
		logic wdog_en;
	} osl_clk_t;

endpackage : osl_pkg

// ==== tb/osl_core_model.sv ====
// CPU core and reset pin model that faces the low-power controller
`timescale 1ns/1ps
`default_nettype none
module osl_core_model (
	// Clock
	input  wire logic pclk,
	// Mode requests
	output logic      stop_req,
	output logic      wait_req,
	// Reset pin, idles high
	output logic      reset_pin_n
);
	logic stop_level;
	logic wait_level;
	logic reset_level_n;

	// Ports follow the request levels, so each port has one continuous driver
	assign stop_req    = stop_level;
	assign wait_req    = wait_level;
	assign reset_pin_n = reset_level_n;

	initial begin
		stop_level    = 1'b0;
		wait_level    = 1'b0;
		reset_level_n = 1'b1;
	end

	// One low-power instruction, held across one edge only
	task sleep(input logic stop);
		stop_level <= stop;
		wait_level <= !stop;
		@(posedge pclk);
		stop_level <= 1'b0;
		wait_level <= 1'b0;
	endtask : sleep

	// Supply dip is not modelled, so the pin simply stays low for the whole span
	task retain(input int n);
		reset_level_n <= 1'b0;
		repeat (n) @(posedge pclk);
		reset_level_n <= 1'b1;
	endtask : retain
endmodule : osl_core_model
`default_nettype wire

// ==== tb/osl_select_lowpower_ctrl_tb_top.sv ====
// Self-checking bench for the oscillator select and low-power controller
`timescale 1ns/1ps
`default_nettype none
module osc_select_lowpower_ctrl_tb_top
	import osl_pkg::*;
();
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        stop_req, wait_req, wake, clr_i_mask, chip_reset_req, wdog_timeout;
	logic        core_timer_clear, prog_timer_clear, irq_pin_n, reset_pin_n, err;
	logic [15:0] vector;
	logic [3:0]  porta_wake_pins;
	osl_irq_t    periph_irq;
	osl_clk_t    clk;
	logic        prev_sel, prev_cpu;
	int          mismatches, checked, n_mask, n_ct, n_pt;
	logic [31:0] sel_w [4] = '{32'h91, 32'h81, 32'h80, 32'h90};
	logic [5:0]  sel_c [4] = '{6'h37, 6'h1f, 6'h27, 6'h27};
	logic [15:0] per_v [4] = '{16'h1ff8, 16'h1ff6, 16'h1ff4, 16'h1ff2};

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	osl_ctrl u_osl_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_req(stop_req), .wait_req(wait_req), .wake(wake),
		.vector(vector), .clr_i_mask(clr_i_mask), .chip_reset_req(chip_reset_req),
		.periph_irq(periph_irq), .wdog_timeout(wdog_timeout),
		.core_timer_clear(core_timer_clear), .prog_timer_clear(prog_timer_clear),
		.irq_pin_n(irq_pin_n), .porta_wake_pins(porta_wake_pins),
		.reset_pin_n(reset_pin_n), .clk(clk));

	osl_core_model u_osl_core_model (.pclk(pclk), .stop_req(stop_req), .wait_req(wait_req),
		.reset_pin_n(reset_pin_n));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// An idle cycle after each transfer keeps psel from being driven twice in one step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check({31'h0, pready}, 32'h1);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask : rd

	task wait_wake(input int lo, input int hi, input logic [15:0] v);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (wake !== 1'b1 && n < hi + 8);
		check({31'h0, n >= lo && n <= hi}, 32'h1);
		check({16'h0, vector}, {16'h0, v});
	endtask : wait_wake

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test

	// Select may only move while the CPU clock is held off
	always @(posedge pclk) begin
		if (clr_i_mask === 1'b1) n_mask++;
		if (core_timer_clear === 1'b1) n_ct++;
		if (prog_timer_clear === 1'b1) n_pt++;
		if (presetn === 1'b1 && clk.sel_ext !== prev_sel) check({31'h0, prev_cpu}, 32'h0);
		prev_sel = clk.sel_ext;
		prev_cpu = clk.cpu_en;
	end

	initial begin
		#(25 * 20000);
		mismatches++;
		stop_test();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{periph_irq, wdog_timeout, porta_wake_pins, prev_sel, prev_cpu} = '0;
		irq_pin_n = 1'b1;
		{mismatches, checked, n_mask, n_ct, n_pt} = '0;
		tick(16);
		presetn <= 1'b1;
		tick(1);
		check({26'h0, clk}, 32'h27);
		rd(ADDR_ICS, 32'h90);
		rd(ADDR_OPT, 32'h0);
		rd(ADDR_STAT, 32'h1ffe0000);
		rd(8'h0c, 32'h0);
		check({31'h0, err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			// The both-on step comes first, so the external osc has settled before the switch
			apb(1'b1, ADDR_ICS, sel_w[i]);
			tick(12);
			check({26'h0, clk}, {26'h0, sel_c[i]});
			rd(ADDR_ICS, sel_w[i]);
		end
		apb(1'b1, ADDR_ICS, 32'h10);
		u_osl_core_model.sleep(1'b0);
		tick(3);
		check(n_mask, 1);
		check({26'h0, clk}, 32'h23);
		rd(ADDR_ICS, 32'h90);
		irq_pin_n <= 1'b0;
		wait_wake(1, 3, 16'h1ffa);
		rd(ADDR_ICS, 32'h98);
		apb(1'b1, ADDR_ICS, 32'h9a);
		rd(ADDR_ICS, 32'h90);
		irq_pin_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			u_osl_core_model.sleep(1'b0);
			tick(2);
			periph_irq <= osl_irq_t'(4'b1000 >> i);
			wait_wake(1, 3, per_v[i]);
			periph_irq <= '0;
			tick(2);
		end
		u_osl_core_model.sleep(1'b0);
		tick(2);
		wdog_timeout <= 1'b1;
		tick(3);
		check({31'h0, chip_reset_req}, 32'h1);
		check({16'h0, vector}, 32'h1ffe);
		wdog_timeout <= 1'b0;
		tick(3);
		rd(ADDR_STAT, 32'h1ffe0000);
		apb(1'b1, ADDR_ICS, 32'h11);
		tick(12);
		u_osl_core_model.sleep(1'b1);
		tick(3);
		check(n_ct, 1);
		check(n_pt, 1);
		check(n_mask, 7);
		check({26'h0, clk}, 32'h0);
		rd(ADDR_ICS, 32'h91);
		wdog_timeout <= 1'b1;
		porta_wake_pins <= 4'h1;
		tick(30);
		check({31'h0, chip_reset_req}, 32'h0);
		rd(ADDR_STAT, 32'h1ffe0001);
		wdog_timeout <= 1'b0;
		porta_wake_pins <= 4'h0;
		irq_pin_n <= 1'b0;
		wait_wake(16, 22, 16'h1ffa);
		irq_pin_n <= 1'b1;
		tick(2);
		check({26'h0, clk}, 32'h37);
		apb(1'b1, ADDR_OPT, 32'h5);
		u_osl_core_model.sleep(1'b1);
		tick(3);
		porta_wake_pins <= 4'h8;
		wait_wake(4064, 4070, 16'h1ffa);
		porta_wake_pins <= 4'h0;
		apb(1'b1, ADDR_OPT, 32'h2);
		u_osl_core_model.sleep(1'b1);
		tick(3);
		check(n_ct, 2);
		check({26'h0, clk}, 32'h33);
		rd(ADDR_STAT, 32'h1ffa0003);
		periph_irq <= osl_irq_t'(4'b0001);
		wait_wake(16, 22, 16'h1ff2);
		periph_irq <= '0;
		apb(1'b1, ADDR_OPT, 32'h4);
		u_osl_core_model.sleep(1'b1);
		tick(3);
		fork
			u_osl_core_model.retain(20);
			begin
				tick(10);
				check({31'h0, chip_reset_req}, 32'h1);
			end
		join
		tick(3);
		check({16'h0, vector}, 32'h1ffe);
		rd(ADDR_STAT, 32'h1ffe0000);
		rd(ADDR_ICS, 32'h90);
		rd(ADDR_OPT, 32'h4);
		// Second power-on reset in mid-run also clears the option word
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		check({26'h0, clk}, 32'h27);
		check({31'h0, chip_reset_req}, 32'h0);
		rd(ADDR_ICS, 32'h90);
		rd(ADDR_OPT, 32'h0);
		rd(ADDR_STAT, 32'h1ffe0000);
		stop_test();
	end
endmodule : osc_select_lowpower_ctrl_tb_top
`default_nettype wire
